// *** logic/dlr_consts.svh ***
// How it works
// - Read-modify-write lowers write-enable after column strobe.
// - Hold column strobe and write-enable low together.
// - Refresh all 64 rows every 2 ms.
// - Refresh cycles keep chip select deasserted.
// - Refresh uses row strobe only, column idle.
// - Column strobe restores output after refresh runs.
// - Column strobe reaches all chips for deselection.
// - Single chip: chip select low only while column strobe is low, high during the row phase.
// - Eight refresh cycles before first access.
`ifndef DLR_CONSTS_SVH
`define DLR_CONSTS_SVH

`define DLR_CLK_NS      50
`define DLR_ROWS        64
`define DLR_T_RFSH_NS   2000000
`define DLR_REF_CYC     ((`DLR_T_RFSH_NS / `DLR_ROWS) / `DLR_CLK_NS)
`define DLR_T_RAS_NS    150
`define DLR_RAS_CYC     ((`DLR_T_RAS_NS + `DLR_CLK_NS - 1) / `DLR_CLK_NS)
`define DLR_T_CAS_NS    100
`define DLR_CAS_CYC     ((`DLR_T_CAS_NS + `DLR_CLK_NS - 1) / `DLR_CLK_NS)
`define DLR_T_RP_NS     100
`define DLR_RP_CYC      ((`DLR_T_RP_NS + `DLR_CLK_NS - 1) / `DLR_CLK_NS)
`define DLR_T_WP_NS     45
`define DLR_WP_CYC      ((`DLR_T_WP_NS + `DLR_CLK_NS - 1) / `DLR_CLK_NS)
`define DLR_INIT_REFS   8
`define DLR_PEND_URGENT 4
`define DLR_PEND_MAX    7
`define DLR_ROW_LSB     0
`define DLR_COL_LSB     6

`endif

// *** logic/dlr_pkg.sv ***
package dlr_pkg;

	typedef struct packed {
		logic        write;
		logic        rmw;
		logic [11:0] addr;
		logic        wdata;
	} dlr_req_t;

	typedef struct packed {
		logic       rasN;
		logic       casN;
		logic       weN;
		logic       csN;
		logic [5:0] addr;
		logic       din;
	} dlr_pins_t;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_ROW  = 6'h02,
		S_COL  = 6'h04,
		S_WE   = 6'h08,
		S_PRE  = 6'h10,
		S_REF  = 6'h20
	} dlr_state_t;

endpackage

// *** logic/dlr_refresh_timer.sv ***
`timescale 1ns/10ps
`include "dlr_consts.svh"
module dlr_refresh_timer
	import dlr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       refDone,
	output logic            refPending,
	output logic            refUrgent,
	output logic [5:0]      rowAddr
);

	logic [9:0] divCnt_ff;
	logic       tick_ff;
	logic [2:0] pendCnt_ff;
	logic [5:0] rowCnt_ff;

	// Divider makes one refresh slot per row within the refresh period.
	always_ff @(posedge clk) begin
		if (srst) begin
			divCnt_ff <= 10'h000;
			tick_ff   <= 1'b0;
		end else if (divCnt_ff == 10'(`DLR_REF_CYC - 1)) begin
			divCnt_ff <= 10'h000;
			tick_ff   <= 1'b1;
		end else begin
			divCnt_ff <= divCnt_ff + 10'h001;
			tick_ff   <= 1'b0;
		end
	end

	// Pending slots; a new slot and a finished refresh in one cycle cancel.
	always_ff @(posedge clk) begin
		if (srst) begin
			pendCnt_ff <= 3'h0;
		end else if (tick_ff && !refDone && pendCnt_ff != 3'(`DLR_PEND_MAX)) begin
			pendCnt_ff <= pendCnt_ff + 3'h1;
		end else if (!tick_ff && refDone && pendCnt_ff != 3'h0) begin
			pendCnt_ff <= pendCnt_ff - 3'h1;
		end
	end

	// Row counter walks every row in turn.
	always_ff @(posedge clk) begin
		if (srst) begin
			rowCnt_ff <= 6'h00;
		end else if (refDone) begin
			rowCnt_ff <= rowCnt_ff + 6'h01;
		end
	end

	assign refPending = (pendCnt_ff != 3'h0);
	assign refUrgent  = (pendCnt_ff >= 3'(`DLR_PEND_URGENT));
	assign rowAddr    = rowCnt_ff;

endmodule // dlr_refresh_timer

// *** logic/dlr_ctrl.sv ***
`timescale 1ns/10ps
`include "dlr_consts.svh"
module dlr_ctrl
	import dlr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       reqValid,
	input  wire dlr_req_t   req,
	output logic            reqReady,
	output logic            rspValid,
	output logic            rspData,
	output dlr_pins_t       pins,
	input  wire logic       dout,
	output logic            initDone
);

	dlr_state_t state_ff;
	dlr_req_t   cur_ff;
	dlr_pins_t  pins_ff;
	logic [3:0] cnt_ff;
	logic [3:0] initCnt_ff;
	logic       initDone_ff;
	logic       reqReady_ff;
	logic       rspValid_ff;
	logic       rspData_ff;
	logic       refDone_ff;
	logic       refPending;
	logic       refUrgent;
	logic [5:0] rowAddr;
	logic       take;
	logic       refWant;
	dlr_state_t nxtState;

	dlr_refresh_timer u_timer (
		.clk        (clk),
		.srst       (srst),
		.refDone    (refDone_ff),
		.refPending (refPending),
		.refUrgent  (refUrgent),
		.rowAddr    (rowAddr)
	);

	assign take    = (state_ff == S_IDLE) && reqValid && reqReady_ff;
	assign refWant = refPending || !initDone_ff;

	// Next state, used for the ready flag.
	always_comb begin
		nxtState = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (take) begin
					nxtState = S_ROW;
				end else if (refWant) begin
					nxtState = S_REF;
				end
			end
			S_ROW: begin
				nxtState = S_COL;
			end
			S_COL: begin
				if (cnt_ff == 4'(`DLR_CAS_CYC - 1)) begin
					nxtState = cur_ff.rmw ? S_WE : S_PRE;
				end
			end
			S_WE: begin
				if (cnt_ff == 4'(`DLR_WP_CYC)) begin
					nxtState = S_PRE;
				end
			end
			S_REF: begin
				if (cnt_ff == 4'(`DLR_RAS_CYC - 1)) begin
					nxtState = S_PRE;
				end
			end
			S_PRE: begin
				if (cnt_ff == 4'(`DLR_RP_CYC - 1)) begin
					nxtState = S_IDLE;
				end
			end
			default: begin
				nxtState = S_IDLE;
			end
		endcase
	end

	// State and phase counter.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= S_IDLE;
			cnt_ff   <= 4'h0;
		end else begin
			state_ff <= nxtState;
			cnt_ff   <= (nxtState != state_ff) ? 4'h0 : cnt_ff + 4'h1;
		end
	end

	// Request capture.
	always_ff @(posedge clk) begin
		if (srst) begin
			cur_ff <= '0;
		end else if (take) begin
			cur_ff <= req;
		end
	end

	// Device pins.
	always_ff @(posedge clk) begin
		if (srst) begin
			pins_ff <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, csN: 1'b1, addr: 6'h00, din: 1'b0};
		end else begin
			case (nxtState)
				S_ROW: begin
					pins_ff.rasN <= 1'b0;
					pins_ff.addr <= req.addr[`DLR_ROW_LSB +: 6];
					pins_ff.weN  <= 1'b1;
				end
				S_COL: begin
					pins_ff.casN <= 1'b0;
					pins_ff.csN  <= 1'b0;
					pins_ff.addr <= cur_ff.addr[`DLR_COL_LSB +: 6];
					pins_ff.din  <= cur_ff.wdata;
					pins_ff.weN  <= !(cur_ff.write && !cur_ff.rmw);
				end
				S_WE: begin
					pins_ff.weN  <= 1'b0;
				end
				S_REF: begin
					pins_ff.rasN <= 1'b0;
					pins_ff.casN <= 1'b1;
					pins_ff.csN  <= 1'b1;
					pins_ff.weN  <= 1'b1;
					pins_ff.addr <= rowAddr;
				end
				default: begin
					pins_ff.rasN <= 1'b1;
					pins_ff.casN <= 1'b1;
					pins_ff.weN  <= 1'b1;
					pins_ff.csN  <= 1'b1;
				end
			endcase
		end
	end

	// Read data is sampled once the column access time has passed.
	always_ff @(posedge clk) begin
		if (srst) begin
			rspValid_ff <= 1'b0;
			rspData_ff  <= 1'b0;
		end else begin
			rspValid_ff <= (state_ff == S_COL) && (nxtState != S_COL);
			if ((state_ff == S_COL) && (nxtState != S_COL)) begin
				rspData_ff <= (cur_ff.write && !cur_ff.rmw) ? cur_ff.wdata : dout;
			end
		end
	end

	// Refresh bookkeeping and power-up count.
	always_ff @(posedge clk) begin
		if (srst) begin
			refDone_ff  <= 1'b0;
			initCnt_ff  <= 4'h0;
			initDone_ff <= 1'b0;
		end else begin
			refDone_ff <= (state_ff == S_REF) && (nxtState == S_PRE);
			if (refDone_ff && !initDone_ff) begin
				initCnt_ff <= initCnt_ff + 4'h1;
			end
			initDone_ff <= (initCnt_ff == 4'(`DLR_INIT_REFS));
		end
	end

	// Ready only when idle, initialised and refresh is not urgent.
	always_ff @(posedge clk) begin
		if (srst) begin
			reqReady_ff <= 1'b0;
		end else begin
			reqReady_ff <= (nxtState == S_IDLE) && !take && initDone_ff && !refUrgent;
		end
	end

	assign reqReady = reqReady_ff;
	assign rspValid = rspValid_ff;
	assign rspData  = rspData_ff;
	assign pins     = pins_ff;
	assign initDone = initDone_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_casAfterRas;
		$fell(pins_ff.casN) |-> !pins_ff.rasN && !pins_ff.csN;
	endproperty
	a_casAfterRas: assert property (p_casAfterRas) else $error("CAS without RAS and select.");

	property p_colAddr;
		$fell(pins_ff.casN) |-> pins_ff.addr == cur_ff.addr[11:6];
	endproperty
	a_colAddr: assert property (p_colAddr) else $error("Column address wrong.");

	property p_earlyWrite;
		$fell(pins_ff.casN) && cur_ff.write && !cur_ff.rmw |-> !pins_ff.weN && pins_ff.din == cur_ff.wdata;
	endproperty
	a_earlyWrite: assert property (p_earlyWrite) else $error("Early write not set up.");

	property p_rmwOrder;
		$fell(pins_ff.weN) |-> !pins_ff.casN &&
			(cur_ff.rmw ? $past(!pins_ff.casN, 2) : $fell(pins_ff.casN));
	endproperty
	a_rmwOrder: assert property (p_rmwOrder) else $error("Late write before CAS.");

	property p_weHold;
		$fell(pins_ff.weN) |=> !pins_ff.weN && !pins_ff.casN;
	endproperty
	a_weHold: assert property (p_weHold) else $error("Write pulse too short.");

	property p_rasWidth;
		$fell(pins_ff.rasN) |-> !pins_ff.rasN [*3] ##1 1'b1;
	endproperty
	a_rasWidth: assert property (p_rasWidth) else $error("RAS pulse too short.");

	property p_refOnly;
		state_ff == S_REF |-> pins_ff.casN && pins_ff.csN && pins_ff.addr == rowAddr;
	endproperty
	a_refOnly: assert property (p_refOnly) else $error("Refresh drives CAS or select.");

	property p_initGate;
		reqReady_ff |-> initDone_ff && initCnt_ff == 4'h8;
	endproperty
	a_initGate: assert property (p_initGate) else $error("Ready before power-up refreshes.");

	property p_urgent;
		state_ff == S_IDLE && refUrgent && !reqReady_ff |=> state_ff == S_REF;
	endproperty
	a_urgent: assert property (p_urgent) else $error("Urgent refresh not served.");

	property p_rowStep;
		refDone_ff |=> rowAddr == $past(rowAddr) + 6'h01;
	endproperty
	a_rowStep: assert property (p_rowStep) else $error("Refresh row did not step.");

	property p_readRsp;
		$fell(pins_ff.casN) && !cur_ff.write |-> ##2 rspValid_ff;
	endproperty
	a_readRsp: assert property (p_readRsp) else $error("Read answer late.");

	c_read: cover property (take && !req.write);
	c_write: cover property (take && req.write && !req.rmw);
	c_rmw: cover property ($fell(pins_ff.weN) && cur_ff.rmw);
	c_refresh: cover property (refDone_ff && initDone_ff);

endmodule // dlr_ctrl

// *** bench/dlr_dram_model.sv ***
`timescale 1ns/10ps
module dlr_dram_model
	import dlr_pkg::*;
(
	input  wire dlr_pins_t pins,
	output logic           dout
);
	logic        mem [0:4095];
	logic [5:0]  rowLat;
	logic [11:0] adr;
	logic        sel;
	logic        valid;
	logic        dq;
	logic        junk;
	int          refRun;
	realtime     casT;
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = 1'b0;
		{sel, valid, dq, junk} = 4'h0;
		refRun = 0;
		casT = 0.0;
		forever #50 junk = ~junk;
	end
	assign dout = valid ? dq : junk;
	always @(negedge pins.rasN) begin
		rowLat = pins.addr;
		refRun++;
		if (pins.casN && refRun > 4) valid = 1'b0;
	end
	always @(negedge pins.casN) begin
		casT = $realtime;
		refRun = 0;
		adr = {pins.addr, rowLat};
		sel = !pins.rasN && !pins.csN;
		valid = 1'b0;
		if (sel && !pins.weN) mem[adr] = pins.din;
		#40 dq = mem[adr];
		valid = sel;
	end
	always @(negedge pins.weN) #1 if (!pins.casN && sel && casT + 1 < $realtime) mem[adr] = pins.din;
endmodule // dlr_dram_model

// *** bench/tb_dram_data_latch_and_refresh.sv ***
`timescale 1ns/10ps
module tb_dram_data_latch_and_refresh import dlr_pkg::*;;
	logic        clk;
	logic        srst;
	logic        reqValid;
	dlr_req_t    req;
	logic        reqReady;
	logic        rspValid;
	logic        rspData;
	dlr_pins_t   pins;
	logic        dout;
	logic        initDone;
	logic        shadow [0:4095];
	logic        rasPrev;
	logic        casSeen;
	logic [31:0] r;
	int          n_mismatch;
	int          cmp_count;
	int          refCnt;
	int          seed;
	int          base;

	dlr_ctrl dut (.clk(clk), .srst(srst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData), .pins(pins), .dout(dout), .initDone(initDone));
	dlr_dram_model farEnd (.pins(pins), .dout(dout));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	task automatic check_cnt(input int got, input int exp, input string what);
		cmp_count++;
		if (got != exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	function automatic logic predict(input logic w, input logic m, input logic [11:0] a,
		input logic d);
		logic v;
		v = (w && !m) ? d : shadow[a];
		if (w) shadow[a] = d;
		return v;
	endfunction

	always @(posedge clk) begin
		rasPrev <= pins.rasN;
		if (pins.rasN === 1'b0 && pins.casN === 1'b0) casSeen = 1'b1;
		if (rasPrev === 1'b0 && pins.rasN === 1'b1) begin
			if (!casSeen) refCnt++;
			casSeen = 1'b0;
		end
		if (pins.casN === 1'b1) check_bit(pins.csN, 1'b1, "select outside column");
		if (initDone !== 1'b1 && !srst) check_bit(pins.casN, 1'b1, "access in init");
	end

	task automatic access(input logic w, input logic m, input logic [11:0] a, input logic d);
		int   n;
		logic exp;
		logic first;
		exp = predict(w, m, a, d);
		first = 1'b1;
		@(posedge clk);
		req <= '{write: w, rmw: m, addr: a, wdata: d};
		reqValid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (reqReady !== 1'b1 && n < 3000);
		if (reqReady !== 1'b1) begin
			n_mismatch++;
			test_done();
		end
		reqValid <= 1'b0;
		#1;
		check_bit(pins.rasN === 1'b0 && pins.addr === a[5:0], 1'b1, "row address");
		for (n = 0; n < 9 && rspValid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (pins.casN === 1'b0 && first) begin
				check_bit(pins.addr === a[11:6], 1'b1, "column address");
				check_bit(pins.weN, !(w && !m), "write strobe");
				check_bit(pins.csN, 1'b0, "select");
				first = 1'b0;
			end
		end
		check_cnt(n, 3, "answer latency");
		check_bit(rspData, exp, "data");
		if (m) check_bit(pins.weN | pins.casN, 1'b0, "late write strobes");
	endtask

	initial begin
		seed = 38;
		srst = 1'b1;
		reqValid = 1'b0;
		req = '0;
		{rasPrev, casSeen} = 2'h2;
		{n_mismatch, cmp_count, refCnt} = '0;
		for (int i = 0; i < 4096; i++) shadow[i] = 1'b0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		access(1'b1, 1'b0, 12'h000, 1'b1);
		check_cnt(refCnt, 8, "init refreshes");
		check_bit(initDone, 1'b1, "init done");
		access(1'b1, 1'b0, 12'hFFF, 1'b1);
		access(1'b1, 1'b1, 12'hFFF, 1'b0);
		access(1'b0, 1'b0, 12'hFFF, 1'b0);
		access(1'b0, 1'b0, 12'h000, 1'b0);
		for (int i = 0; i < 300; i++) begin
			r = $random(seed);
			access(r[0] | r[1], r[1], r[15:4] & 12'hC41, r[2]);
		end
		repeat (100) @(posedge clk);
		base = refCnt;
		repeat (2500) @(posedge clk);
		check_cnt(refCnt - base, 4, "refresh rate");
		access(1'b0, 1'b0, 12'hFFF, 1'b0);
		test_done();
	end
endmodule // tb_dram_data_latch_and_refresh
